/* File: common/dbg_frame_defs.svh */
`ifndef DBG_FRAME_DEFS_SVH
`define DBG_FRAME_DEFS_SVH

// timing
`define CLK_HZ 10000000
`define BAUD_RATE 115200
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)

// frame layout
`define FRAME_LAST 7'h6a
`define HDR0 8'h0d
`define HDR1 8'h0a
`define HDR2 8'h80
`define TAIL_BYTE 8'hff
`define MARK_SUPPLY 8'h01
`define MARK_GROUND 8'h02
`define RAW_FIRST 7'h06
`define BASE_FIRST 7'h28
`define DIFF_FIRST 7'h4a

// self-test thresholds
`define CP_HIGH_PF 8'h28
`define CMOD_LOW_TENTHS 8'h0a
`define CMOD_HIGH_TENTHS 8'h28
`define CMOD_IN_RANGE 8'h00
`define CMOD_ABOVE 8'h01
`define CMOD_BELOW 8'h02

// register map, byte addresses
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_FWREV 8'h08
`define ADR_DIAG 8'h0c
`define CTRL_RESET 1'b1
`define FWREV_RESET 8'h01

`endif

/* File: common/dbg_frame_pkg.sv */
`default_nettype none
package dbg_frame_pkg;
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_LOAD,
        FR_SEND
    } frame_state_t;
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } tx_state_t;
endpackage
`default_nettype wire

/* File: hw/serial_byte_tx.sv */
`include "dbg_frame_defs.svh"
`default_nettype none
module serial_byte_tx (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // byte handshake
    input wire logic [7:0] data_i,
    input wire logic valid_i,
    output logic ready_o,
    // line
    output logic txd_o
);
    localparam logic [7:0] BIT_LAST = 8'(`BIT_CYCLES - 1);

    dbg_frame_pkg::tx_state_t state_reg;
    logic [7:0] shift_reg;
    logic [7:0] tick_reg;
    logic [2:0] bit_reg;

    // character sequencer: start, eight data lsb first, stop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= dbg_frame_pkg::TX_IDLE;
            shift_reg <= 8'h00;
            tick_reg <= 8'h00;
            bit_reg <= 3'h0;
            txd_o <= 1'b1;
        end else begin
            case (state_reg)
                dbg_frame_pkg::TX_IDLE: begin
                    txd_o <= 1'b1;
                    if (valid_i) begin
                        shift_reg <= data_i;
                        tick_reg <= 8'h00;
                        txd_o <= 1'b0; // start bit
                        state_reg <= dbg_frame_pkg::TX_START;
                    end
                end
                dbg_frame_pkg::TX_START: begin
                    if (tick_reg == BIT_LAST) begin
                        tick_reg <= 8'h00;
                        bit_reg <= 3'h0;
                        txd_o <= shift_reg[0]; // lsb first
                        state_reg <= dbg_frame_pkg::TX_DATA;
                    end else begin
                        tick_reg <= tick_reg + 8'h01;
                    end
                end
                dbg_frame_pkg::TX_DATA: begin
                    if (tick_reg == BIT_LAST) begin
                        tick_reg <= 8'h00;
                        if (bit_reg == 3'h7) begin
                            txd_o <= 1'b1; // stop bit
                            state_reg <= dbg_frame_pkg::TX_STOP;
                        end else begin
                            bit_reg <= bit_reg + 3'h1;
                            txd_o <= shift_reg[bit_reg + 3'h1];
                        end
                    end else begin
                        tick_reg <= tick_reg + 8'h01;
                    end
                end
                dbg_frame_pkg::TX_STOP: begin
                    if (tick_reg == BIT_LAST) begin
                        tick_reg <= 8'h00;
                        state_reg <= dbg_frame_pkg::TX_IDLE;
                    end else begin
                        tick_reg <= tick_reg + 8'h01;
                    end
                end
                default: state_reg <= dbg_frame_pkg::TX_IDLE;
            endcase
        end
    end

    assign ready_o = (state_reg == dbg_frame_pkg::TX_IDLE);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_start_bit_low: assert property (valid_i && ready_o |=> !txd_o [*8])
        else $error("start bit not low");
    a_stop_bit_high: assert property (state_reg == dbg_frame_pkg::TX_STOP |-> txd_o)
        else $error("stop bit not high");
    a_char_length: assert property (valid_i && ready_o |=> !ready_o [*8])
        else $error("character ended early");
endmodule
`default_nettype wire

/* File: hw/debug_status_frame_tx.sv */
// Function
// - with debug strap set, frames leave serially at about 115200 baud.
// - frame opens with 0x0d, 0x0a, 0x80, version byte, parasitics of buttons 0, 1.
// - bytes 6..25 hold raw counts of buttons 0..9, high byte first.
// - byte 29 pair 0-1 noise ratio, byte 31 pair 2-3; 28 and 30 zero.
// - bytes 32-33 supply-short mask high first, then 0x00 0x01 0x00.
// - byte 37 touch of buttons 8-9, byte 38 zero, byte 39 buttons 0-7.
// - bytes 40..59 hold baselines of buttons 0..9, high byte first.
// - bytes 60..62 hold parasitics of buttons 4, 5, 6 in picofarads.
// - bytes 66-67 ground-short mask high first, then 0x00 0x02.
// - byte 70 compensated current setting, byte 71 outputs 8-9.
// - byte 72 zero, byte 73 outputs 0-7.
// - bytes 74..93 hold difference counts of buttons 0..9, high first.
// - bytes 94..96 parasitics of buttons 7, 8, 9; byte 98 zero.
// - byte 99 range code, 100-101 neighbour short, 102-103 high parasitic.
// - frame ends with 0x00 then 0xff, 0xff at 104..106.
// - self-test results land in four diagnostic fields; the high parasitic field follows live parasitic values.
// - supply mask low byte buttons 7..0, high bits 1,0 buttons 9,8.
// - ground mask uses the same mapping, one means shorted to ground.
// - range code 0 within 1..4 nF, 1 above 4 nF, 2 below 1 nF.
// - neighbour short mask uses same mapping, one means shorted to another.
// - high parasitic mask bits 5,4 of high byte; set above 40 pF.
//
// The register offsets and register access over Wishbone were decided locally.
`include "dbg_frame_defs.svh"
`default_nettype none
module debug_status_frame_tx (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // strap and sensing state
    input wire logic debug_strap_i,
    input wire logic [159:0] button_raw_value_i,
    input wire logic [159:0] button_baseline_value_i,
    input wire logic [159:0] button_difference_value_i,
    input wire logic [79:0] button_parasitic_value_i,
    input wire logic [39:0] button_pair_noise_ratio_i,
    input wire logic [9:0] touch_status_i,
    input wire logic [9:0] output_state_flags_i,
    input wire logic [7:0] compensated_current_setting_i,
    // self-test results
    input wire logic power_on_self_test_done_i,
    input wire logic [9:0] supply_short_i,
    input wire logic [9:0] ground_short_i,
    input wire logic [9:0] neighbor_short_i,
    input wire logic [7:0] cmod_tenths_nf_i,
    // delay pin
    output logic serial_o,
    output logic serial_oe_o
);
    dbg_frame_pkg::frame_state_t state_reg;
    logic strap_reg;
    logic strap_done_reg;
    logic enable_reg;
    logic [7:0] firmware_version_byte_reg;
    logic [6:0] index_reg;
    logic [15:0] frame_count_reg;
    logic [159:0] raw_reg;
    logic [159:0] base_reg;
    logic [159:0] diff_reg;
    logic [79:0] cp_reg;
    logic [39:0] snr_reg;
    logic [9:0] touch_reg;
    logic [9:0] outs_reg;
    logic [7:0] idac_reg;
    logic [9:0] supply_mask_reg;
    logic [9:0] ground_mask_reg;
    logic [9:0] neighbor_short_mask_reg;
    logic [9:0] high_parasitic_mask_reg;
    logic [7:0] modulator_cap_range_code_reg;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_ready;
    logic tx_line;
    logic sent;
    logic active;
    logic access;

    // pick one byte of a ten-word array, high byte on even offsets
    function automatic logic [7:0] word_byte(input logic [159:0] vec, input logic [6:0] off);
        logic [15:0] w;
        w = vec[16 * off[6:1] +: 16];
        word_byte = off[0] ? w[7:0] : w[15:8];
    endfunction

    // high byte of a ten-bit mask, buttons 9,8 at bits 1,0
    function automatic logic [7:0] mask_hi(input logic [9:0] m);
        mask_hi = {6'h00, m[9:8]};
    endfunction

    // byte at each frame position
    function automatic logic [7:0] frame_byte(input logic [6:0] i);
        frame_byte = 8'h00;
        if (i >= `RAW_FIRST && i < 7'h1a) begin
            frame_byte = word_byte(raw_reg, i - `RAW_FIRST);
        end else if (i >= `BASE_FIRST && i < 7'h3c) begin
            frame_byte = word_byte(base_reg, i - `BASE_FIRST);
        end else if (i >= `DIFF_FIRST && i < 7'h5e) begin
            frame_byte = word_byte(diff_reg, i - `DIFF_FIRST);
        end else begin
            case (i)
                7'h00: frame_byte = `HDR0;
                7'h01: frame_byte = `HDR1;
                7'h02: frame_byte = `HDR2;
                7'h03: frame_byte = firmware_version_byte_reg;
                7'h04: frame_byte = cp_reg[7:0];
                7'h05: frame_byte = cp_reg[15:8];
                7'h1a: frame_byte = cp_reg[23:16];
                7'h1b: frame_byte = cp_reg[31:24];
                7'h1d: frame_byte = snr_reg[7:0];
                7'h1f: frame_byte = snr_reg[15:8];
                7'h20: frame_byte = mask_hi(supply_mask_reg);
                7'h21: frame_byte = supply_mask_reg[7:0];
                7'h23: frame_byte = `MARK_SUPPLY;
                7'h25: frame_byte = mask_hi(touch_reg);
                7'h27: frame_byte = touch_reg[7:0];
                7'h3c: frame_byte = cp_reg[39:32];
                7'h3d: frame_byte = cp_reg[47:40];
                7'h3e: frame_byte = cp_reg[55:48];
                7'h3f: frame_byte = snr_reg[23:16];
                7'h41: frame_byte = snr_reg[31:24];
                7'h42: frame_byte = mask_hi(ground_mask_reg);
                7'h43: frame_byte = ground_mask_reg[7:0];
                7'h45: frame_byte = `MARK_GROUND;
                7'h46: frame_byte = idac_reg;
                7'h47: frame_byte = mask_hi(outs_reg);
                7'h49: frame_byte = outs_reg[7:0];
                7'h5e: frame_byte = cp_reg[63:56];
                7'h5f: frame_byte = cp_reg[71:64];
                7'h60: frame_byte = cp_reg[79:72];
                7'h61: frame_byte = snr_reg[39:32];
                7'h63: frame_byte = modulator_cap_range_code_reg;
                7'h64: frame_byte = mask_hi(neighbor_short_mask_reg);
                7'h65: frame_byte = neighbor_short_mask_reg[7:0];
                7'h66: frame_byte = {2'h0, high_parasitic_mask_reg[9:8], 4'h0};
                7'h67: frame_byte = high_parasitic_mask_reg[7:0];
                7'h69: frame_byte = `TAIL_BYTE;
                7'h6a: frame_byte = `TAIL_BYTE;
                default: frame_byte = 8'h00;
            endcase
        end
    endfunction

    // strap sampled once, the first edge after reset release
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_reg <= 1'b0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_reg <= debug_strap_i;
            strap_done_reg <= 1'b1;
        end
    end

    assign active = strap_reg && enable_reg;
    assign sent = tx_valid && tx_ready;
    assign tx_valid = (state_reg == dbg_frame_pkg::FR_SEND);
    always_comb tx_byte = frame_byte(index_reg);
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // self-test results captured when the test completes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            supply_mask_reg <= 10'h000;
            ground_mask_reg <= 10'h000;
            neighbor_short_mask_reg <= 10'h000;
            modulator_cap_range_code_reg <= `CMOD_IN_RANGE;
        end else if (power_on_self_test_done_i) begin
            supply_mask_reg <= supply_short_i;
            ground_mask_reg <= ground_short_i;
            neighbor_short_mask_reg <= neighbor_short_i;
            if (cmod_tenths_nf_i < `CMOD_LOW_TENTHS) begin
                modulator_cap_range_code_reg <= `CMOD_BELOW;
            end else if (cmod_tenths_nf_i > `CMOD_HIGH_TENTHS) begin
                modulator_cap_range_code_reg <= `CMOD_ABOVE;
            end else begin
                modulator_cap_range_code_reg <= `CMOD_IN_RANGE;
            end
        end
    end

    // high parasitic flags follow the parasitic values
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_parasitic_mask_reg <= 10'h000;
        end else begin
            for (int b = 0; b < 10; b++) begin
                high_parasitic_mask_reg[b] <= button_parasitic_value_i[8 * b +: 8] > `CP_HIGH_PF;
            end
        end
    end

    // snapshot of sensing state at each frame start
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raw_reg <= '0;
            base_reg <= '0;
            diff_reg <= '0;
            cp_reg <= '0;
            snr_reg <= '0;
            touch_reg <= 10'h000;
            outs_reg <= 10'h000;
            idac_reg <= 8'h00;
        end else if (state_reg == dbg_frame_pkg::FR_LOAD) begin
            raw_reg <= button_raw_value_i;
            base_reg <= button_baseline_value_i;
            diff_reg <= button_difference_value_i;
            cp_reg <= button_parasitic_value_i;
            snr_reg <= button_pair_noise_ratio_i;
            touch_reg <= touch_status_i;
            outs_reg <= output_state_flags_i;
            idac_reg <= compensated_current_setting_i;
        end
    end

    // frame sequencer; a frame started is always finished
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= dbg_frame_pkg::FR_IDLE;
            index_reg <= 7'h00;
            frame_count_reg <= 16'h0000;
        end else begin
            case (state_reg)
                dbg_frame_pkg::FR_IDLE: begin
                    index_reg <= 7'h00;
                    if (active) begin
                        state_reg <= dbg_frame_pkg::FR_LOAD;
                    end
                end
                dbg_frame_pkg::FR_LOAD: begin
                    state_reg <= dbg_frame_pkg::FR_SEND;
                end
                dbg_frame_pkg::FR_SEND: begin
                    if (sent) begin
                        if (index_reg == `FRAME_LAST) begin
                            index_reg <= 7'h00;
                            frame_count_reg <= frame_count_reg + 16'h0001;
                            state_reg <= active ? dbg_frame_pkg::FR_LOAD : dbg_frame_pkg::FR_IDLE;
                        end else begin
                            index_reg <= index_reg + 7'h01;
                        end
                    end
                end
                default: state_reg <= dbg_frame_pkg::FR_IDLE;
            endcase
        end
    end

    // character transmitter
    serial_byte_tx u_tx (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .data_i(tx_byte),
        .valid_i(tx_valid),
        .ready_o(tx_ready),
        .txd_o(tx_line)
    );

    // delay pin driven only while debug output is strapped on
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_o <= 1'b1;
            serial_oe_o <= 1'b0;
        end else begin
            serial_o <= tx_line;
            serial_oe_o <= strap_reg;
        end
    end

    // register writes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_reg <= `CTRL_RESET;
            firmware_version_byte_reg <= `FWREV_RESET;
        end else if (access && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `ADR_CTRL) begin
                enable_reg <= wb_dat_i[0];
            end
            if (wb_adr_i == `ADR_FWREV) begin
                firmware_version_byte_reg <= wb_dat_i[7:0];
            end
        end
    end

    // bus answer one cycle after the request, unmapped reads zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= 32'h0000_0000;
            if (access && !wb_we_i) begin
                case (wb_adr_i)
                    `ADR_CTRL: wb_dat_o <= {31'h0, enable_reg};
                    `ADR_STATUS: wb_dat_o <= {frame_count_reg, 1'b0, index_reg, 5'h00, tx_valid, active, strap_reg};
                    `ADR_FWREV: wb_dat_o <= {24'h0, firmware_version_byte_reg};
                    `ADR_DIAG: wb_dat_o <= {modulator_cap_range_code_reg[1:0], high_parasitic_mask_reg,
                        neighbor_short_mask_reg, ground_mask_reg};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_header_bytes: assert property (sent && index_reg == 7'h00 |-> tx_byte == `HDR0)
        else $error("frame does not open with header");
    a_header_third: assert property (sent && index_reg == 7'h02 |-> tx_byte == `HDR2)
        else $error("third header byte wrong");
    a_raw_first: assert property (sent && index_reg == 7'h06 |-> tx_byte == raw_reg[15:8])
        else $error("raw count not high byte first");
    a_snr_pad: assert property (sent && (index_reg == 7'h1c || index_reg == 7'h1e) |-> tx_byte == 8'h00)
        else $error("pad byte not zero");
    a_supply_mark: assert property (sent && index_reg == 7'h23 |-> tx_byte == `MARK_SUPPLY)
        else $error("supply marker wrong");
    a_ground_mark: assert property (sent && index_reg == 7'h45 |-> tx_byte == `MARK_GROUND)
        else $error("ground marker wrong");
    a_diff_last: assert property (sent && index_reg == 7'h5d |-> tx_byte == diff_reg[151:144])
        else $error("last difference byte wrong");
    a_trailer_bytes: assert property (sent && index_reg > 7'h68 |-> tx_byte == `TAIL_BYTE)
        else $error("trailer not 0xff");
    a_range_below: assert property (power_on_self_test_done_i && cmod_tenths_nf_i < `CMOD_LOW_TENTHS
        |=> modulator_cap_range_code_reg == `CMOD_BELOW)
        else $error("range code below not set");
    a_high_parasitic: assert property (button_parasitic_value_i[79:72] > `CP_HIGH_PF
        |=> high_parasitic_mask_reg[9])
        else $error("high parasitic flag missing");
    a_frame_repeat: assert property (sent && index_reg == `FRAME_LAST && active
        |=> state_reg == dbg_frame_pkg::FR_LOAD ##1 index_reg == 7'h00)
        else $error("frame did not repeat");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    c_frame_done: cover property (sent && index_reg == `FRAME_LAST);
    c_two_frames: cover property (frame_count_reg == 16'h0002);
    c_disable_mid: cover property (tx_valid && !active);
    c_reg_read: cover property (access && !wb_we_i && wb_adr_i == `ADR_STATUS);
endmodule
`default_nettype wire

/* File: bench/serial_rx_model.sv */
`include "dbg_frame_defs.svh"
`default_nettype none
module serial_rx_model (
    // clock and line
    input wire logic clk_i,
    input wire logic line_i,
    // received frame
    output var logic [7:0] frame_o [0:106],
    output var int frames_o,
    output var int bad_stop_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] buf_b [0:106];
    logic [7:0] hdr [0:2] = '{8'h0d, 8'h0a, 8'h80};
    logic [7:0] b;
    int idx = 0;
    // 8n1 receiver sampling mid-bit
    initial begin
        frames_o = 0;
        bad_stop_o = 0;
        forever begin
            @(posedge clk_i);
            if (line_i === 1'b0) begin
                repeat (`BIT_CYCLES / 2) @(posedge clk_i);
                for (int i = 0; i < 8; i++) begin
                    repeat (`BIT_CYCLES) @(posedge clk_i);
                    b[i] = line_i; // lsb first
                end
                repeat (`BIT_CYCLES) @(posedge clk_i);
                if (line_i !== 1'b1) bad_stop_o++;
                buf_b[idx] = b;
                // resync on a broken header
                if (idx < 3 && b !== hdr[idx]) idx = (b === 8'h0d) ? 1 : 0;
                else idx++;
                // frame closes on the trailer
                if (idx == 107) begin
                    idx = 0;
                    if (buf_b[105] === 8'hff && buf_b[106] === 8'hff) begin
                        frame_o = buf_b;
                        frames_o++;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`include "dbg_frame_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [159:0] raw_v, base_v, diff_v;
    logic [79:0] cp_v;
    logic [39:0] snr_v;
    logic [9:0] hp_v;
    logic [9:0] touch_v = 10'h2a5;
    logic [9:0] out_v = 10'h15a;
    logic [9:0] sup_v = 10'h301;
    logic [9:0] gnd_v = 10'h0c2;
    logic [9:0] nb_v = 10'h210;
    logic [7:0] idac_v = 8'h77;
    logic [7:0] cmod_v = 8'h29;
    logic power_on_self_test_v = 1'b0;
    logic strap_v = 1'b1;
    logic serial_o, serial_oe_o;
    logic [7:0] rx_frame [0:106];
    logic [7:0] e [0:106];
    logic [31:0] rd;
    int rx_frames, rx_bad_stop;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    debug_status_frame_tx debug_status_frame_tx_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .debug_strap_i(strap_v), .button_raw_value_i(raw_v),
        .button_baseline_value_i(base_v), .button_difference_value_i(diff_v), .button_parasitic_value_i(cp_v),
        .button_pair_noise_ratio_i(snr_v), .touch_status_i(touch_v), .output_state_flags_i(out_v),
        .compensated_current_setting_i(idac_v), .power_on_self_test_done_i(power_on_self_test_v), .supply_short_i(sup_v),
        .ground_short_i(gnd_v), .neighbor_short_i(nb_v), .cmod_tenths_nf_i(cmod_v), .serial_o(serial_o),
        .serial_oe_o(serial_oe_o));
    serial_rx_model serial_rx_model_inst (.clk_i(clk_i), .line_i(serial_o), .frame_o(rx_frame),
        .frames_o(rx_frames), .bad_stop_o(rx_bad_stop));
    // clock and hang guard
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 98000) begin
            err_total++;
            $display("CHECK FAILED run length expected done seen timeout");
            stop_test();
        end
    end
    task automatic check(input string name, input logic [31:0] ev, input logic [31:0] got);
        samples_checked++;
        if (got !== ev) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, ev, got);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // classic single wishbone cycle, released after ack
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        check("bus ack", 32'h1, {31'h0, wb_ack_o});
    endtask
    task automatic t_bit_time();
        int n;
        n = 0;
        while (serial_o !== 1'b0 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (serial_o === 1'b0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        check("start bit cycles", `BIT_CYCLES, n);
        check("pin drive", 32'h1, {31'h0, serial_oe_o});
    endtask
    task automatic t_regs();
        @(posedge clk_i) power_on_self_test_v <= 1'b1;
        @(posedge clk_i) power_on_self_test_v <= 1'b0;
        wb(1'b0, `ADR_CTRL, 32'h0, rd);
        check("enable reset", 32'h1, rd);
        wb(1'b0, `ADR_FWREV, 32'h0, rd);
        check("version reset", 32'h01, rd);
        wb(1'b0, 8'h10, 32'h0, rd);
        check("unmapped read", 32'h0, rd);
        wb(1'b0, `ADR_STATUS, 32'h0, rd);
        check("strap active", 32'h3, {30'h0, rd[1:0]});
        wb(1'b1, `ADR_CTRL, 32'h0, rd);
        wb(1'b1, `ADR_CTRL, 32'h1, rd);
    endtask
    task automatic cmp_bytes(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) check($sformatf("frame byte %0d", i), {24'h0, e[i]}, {24'h0, rx_frame[i]});
    endtask
    task automatic t_frame();
        int lows;
        e = '{default: 8'h00};
        e[0:3] = '{8'h0d, 8'h0a, 8'h80, 8'h01};
        for (int n = 0; n < 10; n++) begin
            {e[6 + 2 * n], e[7 + 2 * n]} = raw_v[16 * n +: 16];
            {e[40 + 2 * n], e[41 + 2 * n]} = base_v[16 * n +: 16];
            {e[74 + 2 * n], e[75 + 2 * n]} = diff_v[16 * n +: 16];
        end
        {e[4], e[5], e[26], e[27], e[60], e[61], e[62]} = {cp_v[7:0], cp_v[15:8], cp_v[23:16], cp_v[31:24],
            cp_v[39:32], cp_v[47:40], cp_v[55:48]};
        {e[94], e[95], e[96]} = {cp_v[63:56], cp_v[71:64], cp_v[79:72]};
        {e[29], e[31], e[63], e[65], e[97]} = {snr_v[7:0], snr_v[15:8], snr_v[23:16], snr_v[31:24], snr_v[39:32]};
        {e[32], e[33], e[35], e[37], e[39]} = {6'h0, sup_v, 8'h01, 6'h0, touch_v[9:8], touch_v[7:0]};
        {e[66], e[67], e[69], e[70]} = {6'h0, gnd_v, 8'h02, idac_v};
        {e[71], e[73], e[99], e[100], e[101]} = {6'h0, out_v[9:8], out_v[7:0], 8'h01, 6'h0, nb_v};
        {e[102], e[103], e[105], e[106]} = {2'h0, hp_v[9:8], 4'h0, hp_v[7:0], 16'hffff};
        wait (rx_frames > 0);
        cmp_bytes(0, 39);
        cmp_bytes(40, 106);
        check("stop bit faults", 32'h0, rx_bad_stop);
        wb(1'b0, `ADR_STATUS, 32'h0, rd);
        check("frame repeat", 32'h0001_0007, rd);
        strap_v <= 1'b0;
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        lows = 0;
        repeat (2000) begin
            @(posedge clk_i);
            if (serial_o !== 1'b1) lows++;
        end
        check("line after disable", 32'h0, lows);
        check("drive strapped off", 32'h0, {31'h0, serial_oe_o});
        wb(1'b1, `ADR_FWREV, 32'h5a, rd);
        wb(1'b0, `ADR_FWREV, 32'h0, rd);
        check("version write", 32'h5a, rd);
    endtask
    task automatic t_diag();
        logic [7:0] cv [0:3] = '{8'h09, 8'h0a, 8'h28, 8'h29};
        logic [1:0] code [0:3] = '{2'h2, 2'h0, 2'h0, 2'h1};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            cmod_v <= cv[i];
            power_on_self_test_v <= 1'b1;
            @(posedge clk_i) power_on_self_test_v <= 1'b0;
            wb(1'b0, `ADR_DIAG, 32'h0, rd);
            check("diag word", {code[i], hp_v, nb_v, gnd_v}, rd);
        end
    endtask
    // main sequence
    initial begin
        for (int n = 0; n < 10; n++) begin
            raw_v[16 * n +: 16] = 16'ha000 + 16'(n * 257);
            base_v[16 * n +: 16] = 16'h5000 + 16'(n * 3);
            diff_v[16 * n +: 16] = 16'h0f00 + 16'(n * 19);
            cp_v[8 * n +: 8] = 8'(20 + 5 * n);
            hp_v[n] = (20 + 5 * n) > 40;
        end
        for (int k = 0; k < 5; k++) snr_v[8 * k +: 8] = 8'h30 + 8'(k);
        repeat (2) @(posedge clk_i);
        check("line in reset", 32'h1, {31'h0, serial_o});
        check("drive in reset", 32'h0, {31'h0, serial_oe_o});
        @(posedge clk_i) rst_n_i <= 1'b1;
        t_bit_time();
        t_regs();
        t_frame();
        t_diag();
        stop_test();
    end
endmodule
`default_nettype wire
